// ==== verilog/nacr_regs.sv ====
// Purpose: Analog front-end configuration register bank
// Assumes: Fine phase offset and sign come from a register on the same clock
// Notes:   Static controls drive analog circuits straight from flops
//          Unmapped addresses ignore writes and read zero
//
// What this block does
// - Two-bit threshold field, reset 0, selects 30, 50, 65 or 80 percent.
// - Two-bit time-constant field, reset 0: 8, 2, 5 us; code 3 forbidden.
// - Two-bit gain-loop reference field, reset 0: 1.15, 1.4, 1.5, 1.6 V.
// - Three-bit coarse phase field, reset 0, 45 degrees per code step.
// - Effective phase is coarse setting plus fine offset in 5 degree steps.
`timescale 1ns/1ps

module nacr_regs
  import nacr_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_reset,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic [2:0]        i_fine_phase_offset,
  input  wire logic              i_fine_phase_negative,
  output logic      [DATA_W-1:0] o_rdata,
  output nacr_ana_s              o_ana,
  output logic      [8:0]        o_clock_phase_deg
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // Coarse code to degrees
  function automatic logic [8:0] coarse_deg_of(input logic [2:0] code);
    coarse_deg_of = 9'(COARSE_STEP_DEG * {6'h00, code});
  endfunction

  // Fine code to degrees
  function automatic logic [8:0] fine_deg_of(input logic [2:0] code);
    fine_deg_of = 9'(FINE_STEP_DEG * {6'h00, code});
  endfunction

  // Sum kept inside one turn; positive sum never passes a full turn
  function automatic logic [8:0] phase_sum(input logic [8:0] c, input logic [8:0] f, input logic neg);
    if (neg && (f > c)) begin
      phase_sum = 9'(FULL_TURN_DEG + c - f);
    end else if (neg) begin
      phase_sum = 9'(c - f);
    end else begin
      phase_sum = 9'(c + f);
    end
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [16:0]       card_demod_r;
  logic [16:0]       card_demod_nxt;
  logic [3:0]        gain_loop_r;
  logic [3:0]        gain_loop_nxt;
  logic [6:0]        clk_phase_r;
  logic [6:0]        clk_phase_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  nacr_ana_s         ana_r;
  nacr_ana_s         ana_nxt;
  logic [8:0]        phase_r;
  logic [8:0]        phase_nxt;
  logic [8:0]        coarse_deg;
  logic [8:0]        fine_deg;
  logic              wr_card;
  logic              wr_gain;
  logic              wr_clk;
  logic              rd_card;
  logic              rd_gain;
  logic              rd_clk;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // Exact match only, so no alias of a register can write it
  always_comb begin
    wr_card = i_wr && hit(i_addr, CARD_DEMOD_OFS);
    wr_gain = i_wr && hit(i_addr, GAIN_LOOP_OFS);
    wr_clk  = i_wr && hit(i_addr, CLK_PHASE_OFS);
    rd_card = i_rd && hit(i_addr, CARD_DEMOD_OFS);
    rd_gain = i_rd && hit(i_addr, GAIN_LOOP_OFS);
    rd_clk  = i_rd && hit(i_addr, CLK_PHASE_OFS);
  end

  // ----------------------------------------------------------------
  // Card-mode demodulator register
  // ----------------------------------------------------------------
  always_comb begin
    card_demod_nxt = card_demod_r;
    if (wr_card) begin
      // Time-constant code 3 is stored as written
      card_demod_nxt = i_wdata[16:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      // Internal-use bits start at their front-end defaults
      card_demod_r <= CARD_DEMOD_RST;
    end else begin
      card_demod_r <= card_demod_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Gain-loop register
  // ----------------------------------------------------------------
  always_comb begin
    gain_loop_nxt = gain_loop_r;
    if (wr_gain) begin
      // Bit 3 is kept as written, no masking
      gain_loop_nxt = i_wdata[3:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      gain_loop_r <= GAIN_LOOP_RST;
    end else begin
      gain_loop_r <= gain_loop_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Coarse clock phase register
  // ----------------------------------------------------------------
  always_comb begin
    clk_phase_nxt = clk_phase_r;
    if (wr_clk) begin
      clk_phase_nxt = i_wdata[6:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      clk_phase_r <= CLK_PHASE_RST;
    end else begin
      clk_phase_r <= clk_phase_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read port, one cycle latency, unmapped reads zero
  // ----------------------------------------------------------------
  // Read-only bits return zero whatever was written there
  always_comb begin
    rdata_nxt = '0;
    if (rd_card) begin
      rdata_nxt = {15'h0000, card_demod_r};
    end else if (rd_gain) begin
      rdata_nxt = {28'h0000000, gain_loop_r};
    end else if (rd_clk) begin
      rdata_nxt = {25'h0000000, clk_phase_r};
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Analog controls
  // ----------------------------------------------------------------
  // Next values used so controls move on the write edge itself
  always_comb begin
    ana_nxt.card_demod_threshold     = card_demod_nxt[THRESH_LSB +: 2];
    ana_nxt.card_demod_time_constant = card_demod_nxt[TAU_LSB +: 2];
    ana_nxt.gain_loop_powerdown      = gain_loop_nxt[PD_BIT];
    ana_nxt.gain_loop_ref_select     = gain_loop_nxt[VREF_LSB +: 2];
    ana_nxt.coarse_phase_select      = clk_phase_nxt[COARSE_LSB +: 3];
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ana_r <= '0;
    end else begin
      ana_r <= ana_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Effective clock phase
  // ----------------------------------------------------------------
  // Fine inputs are levels from logic on this clock, not synchronised
  always_comb begin
    coarse_deg = coarse_deg_of(ana_nxt.coarse_phase_select);
    fine_deg   = fine_deg_of(i_fine_phase_offset);
    phase_nxt  = phase_sum(coarse_deg, fine_deg, i_fine_phase_negative);
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata           = rdata_r;
  assign o_ana             = ana_r;
  assign o_clock_phase_deg = phase_r;

endmodule // nacr_regs

// ==== shared/nacr_pkg.sv ====
// Purpose: Constants and types for the analog front-end configuration registers
// Assumes: Byte addresses on a 12-bit register port, 32-bit data
// Notes:   Reset values hold the internal-use defaults as well
package nacr_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam logic [11:0] CARD_DEMOD_OFS  = 12'h114;
  localparam logic [11:0] GAIN_LOOP_OFS   = 12'h11c;
  localparam logic [11:0] CLK_PHASE_OFS   = 12'h120;

  // ----------------------------------------------------------------
  // Writable widths and reset values
  // ----------------------------------------------------------------
  localparam logic [16:0] CARD_DEMOD_RST  = 17'h1c080;
  localparam logic [3:0]  GAIN_LOOP_RST   = 4'h0;
  localparam logic [6:0]  CLK_PHASE_RST   = 7'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int THRESH_LSB   = 12;
  localparam int TAU_LSB      = 10;
  localparam int PD_BIT       = 2;
  localparam int VREF_LSB     = 0;
  localparam int COARSE_LSB   = 0;

  // ----------------------------------------------------------------
  // Phase arithmetic, degrees
  // ----------------------------------------------------------------
  localparam logic [8:0] COARSE_STEP_DEG = 9'h02d;
  localparam logic [8:0] FINE_STEP_DEG   = 9'h005;
  localparam logic [8:0] FULL_TURN_DEG   = 9'h168;

  typedef struct packed {
    logic [1:0] card_demod_threshold;
    logic [1:0] card_demod_time_constant;
    logic       gain_loop_powerdown;
    logic [1:0] gain_loop_ref_select;
    logic [2:0] coarse_phase_select;
  } nacr_ana_s;

endpackage : nacr_pkg

// ==== verif/nacr_regs_asserts.sv ====
// Purpose: Assertions on the front-end configuration registers
// Assumes: Writes show on the controls one edge later
// Notes:   Phase output lags its inputs by one edge
`timescale 1ns/1ps
module nacr_regs_chk
  import nacr_pkg::*;
(
  input wire logic              i_mclk,
  input wire logic              i_reset,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [2:0]        i_fine_phase_offset,
  input wire logic              i_fine_phase_negative,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire nacr_ana_s         o_ana,
  input wire logic [8:0]        o_clock_phase_deg
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  wire cd_w = i_wr && i_addr == CARD_DEMOD_OFS;
  wire gl_w = i_wr && i_addr == GAIN_LOOP_OFS;
  wire cp_w = i_wr && i_addr == CLK_PHASE_OFS;
  function automatic int deg(int c, int f, int n);
    return (45 * c + (n ? 360 - 5 * f : 5 * f)) % 360;
  endfunction
  thresh_write_a: assert property (cd_w |=> o_ana.card_demod_threshold == $past(i_wdata[13:12]))
    else $error("threshold not written");
  tau_write_a: assert property (cd_w |=> o_ana.card_demod_time_constant == $past(i_wdata[11:10]))
    else $error("time constant not written");
  vref_write_a: assert property (gl_w |=> o_ana.gain_loop_ref_select == $past(i_wdata[1:0]))
    else $error("reference not written");
  pd_write_a: assert property (gl_w |=> o_ana.gain_loop_powerdown == $past(i_wdata[2]))
    else $error("power-down not written");
  coarse_write_a: assert property (cp_w |=> o_ana.coarse_phase_select == $past(i_wdata[2:0]))
    else $error("coarse phase not written");
  phase_sum_a: assert property (!$past(i_reset) |-> o_clock_phase_deg == 9'(deg(o_ana.coarse_phase_select,
    $past(i_fine_phase_offset), $past(i_fine_phase_negative)))) else $error("phase sum wrong");
  rd_idle_a: assert property (!i_rd |=> o_rdata == '0)
    else $error("read data not zero when idle");
  cover property (cd_w);
  cover property (gl_w ##1 o_ana.gain_loop_powerdown);
  cover property (i_fine_phase_negative && i_fine_phase_offset == 3'h7);
endmodule // nacr_regs_chk
bind nacr_regs nacr_regs_chk chk (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .i_fine_phase_offset(i_fine_phase_offset), .o_rdata(o_rdata), .o_ana(o_ana),
  .i_fine_phase_negative(i_fine_phase_negative), .o_clock_phase_deg(o_clock_phase_deg));

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the configuration registers
// Assumes: Software never writes time-constant code 3; the bench always writes gain-loop bit 3 as zero
// Notes:   Card-mode and gain-loop upper bits written as ones to prove they read back 0
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench import nacr_pkg::*;;
  logic i_mclk = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_fine_phase_negative = 0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0, o_rdata, rv;
  logic [2:0] i_fine_phase_offset = '0;
  logic [8:0] o_clock_phase_deg;
  nacr_ana_s o_ana;
  int failures = 0, checks = 0, cycles = 0;
  nacr_regs dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_fine_phase_offset(i_fine_phase_offset), .i_fine_phase_negative(i_fine_phase_negative),
    .o_rdata(o_rdata), .o_ana(o_ana), .o_clock_phase_deg(o_clock_phase_deg));
  initial forever #10 i_mclk = ~i_mclk;
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk); i_wr <= 1; i_addr <= a; i_wdata <= d;
    @(posedge i_mclk); i_wr <= 0; #1;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge i_mclk); i_rd <= 1; i_addr <= a;
    @(posedge i_mclk); i_rd <= 0; #1 rv = o_rdata;
  endtask
  task automatic t_reset;
    `CHK("ana", 10'h0, o_ana)
    rd(CARD_DEMOD_OFS); `CHK("cd", 32'h1c080, rv)
    rd(GAIN_LOOP_OFS); `CHK("gl", 32'h0, rv)
    rd(CLK_PHASE_OFS); `CHK("cp", 32'h0, rv)
    rd(12'h118); `CHK("hole", 32'h0, rv)
  endtask
  task automatic t_demod;
    for (int t = 0; t < 4; t++) for (int u = 0; u < 3; u++) begin
      wr(CARD_DEMOD_OFS, 32'hfffe0000 | 32'(CARD_DEMOD_RST) | t << 12 | u << 10);
      `CHK("thr", 2'(t), o_ana.card_demod_threshold)
      `CHK("tau", 2'(u), o_ana.card_demod_time_constant)
      rd(CARD_DEMOD_OFS); `CHK("cd", 32'h1c080 | t << 12 | u << 10, rv)
    end
  endtask
  task automatic t_gain;
    for (int v = 0; v < 8; v++) begin
      wr(GAIN_LOOP_OFS, 32'hfffffff0 | v);
      `CHK("pd", v[2], o_ana.gain_loop_powerdown)
      `CHK("ref", 2'(v), o_ana.gain_loop_ref_select)
      rd(GAIN_LOOP_OFS); `CHK("gl", 32'(v), rv)
    end
    wr(12'h118, 32'hfffffff0);
    rd(GAIN_LOOP_OFS); `CHK("gl_hole", 32'h7, rv)
  endtask
  task automatic t_phase;
    for (int n = 0; n < 2; n++) for (int c = 0; c < 8; c++) for (int f = 0; f < 8; f++) begin
      @(posedge i_mclk);
      i_fine_phase_offset <= 3'(f);
      i_fine_phase_negative <= n[0];
      wr(CLK_PHASE_OFS, 32'h78 | c);
      `CHK("crs", 3'(c), o_ana.coarse_phase_select)
      `CHK("deg", 9'((45 * c + (n ? 360 - 5 * f : 5 * f)) % 360), o_clock_phase_deg)
    end
    rd(CLK_PHASE_OFS); `CHK("cp", 32'h7f, rv)
  endtask
  initial begin
    repeat (12) @(posedge i_mclk);
    i_reset <= 0;
    t_reset();
    t_demod();
    t_gain();
    t_phase();
    print_verdict();
  end
endmodule // testbench
